// ===== pmca_pkg.sv
package pmca_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int unsigned PMCA_CLK_MHZ = 200;            // core clock rate
	localparam int unsigned PMCA_WAKE_US = 40;             // power-down recovery time
	localparam int unsigned PMCA_WAKE_CYC = PMCA_WAKE_US * PMCA_CLK_MHZ;
	typedef int unsigned pmca_ct_arr_t [8];                // one entry per conversion-time code
	localparam pmca_ct_arr_t PMCA_CT_US = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};

	// conversion time in core cycles for every conversion-time code
	function automatic pmca_ct_arr_t pmca_ct_cycles();
		pmca_ct_arr_t r;
		for (int i = 0; i < 8; i++)
		begin
			r[i] = PMCA_CT_US[i] * PMCA_CLK_MHZ;
		end
		return r;
	endfunction : pmca_ct_cycles

	localparam pmca_ct_arr_t PMCA_CT_CYC = pmca_ct_cycles();

	//////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] PMCA_OFS_CFG = 8'h00;
	localparam logic [7:0] PMCA_OFS_SHUNT = 8'h01;
	localparam logic [7:0] PMCA_OFS_BUS = 8'h02;
	localparam logic [7:0] PMCA_OFS_POWER = 8'h03;
	localparam logic [7:0] PMCA_OFS_CURRENT = 8'h04;
	localparam logic [7:0] PMCA_OFS_SCALE = 8'h05;
	localparam logic [7:0] PMCA_OFS_MASK = 8'h06;
	localparam logic [7:0] PMCA_OFS_LIMIT = 8'h07;

	// configuration fields
	localparam int PMCA_CFG_MODE_LSB = 0;
	localparam int PMCA_CFG_CTSH_LSB = 3;
	localparam int PMCA_CFG_CTBU_LSB = 6;
	localparam int PMCA_CFG_AVG_LSB = 9;
	localparam logic [15:0] PMCA_CFG_RST = 16'h4127;        // continuous, both channels

	// mask/enable fields
	localparam int PMCA_MSK_EN_LSB = 11;                   // five alert-function enables
	localparam int PMCA_MSK_DONE_TO_ALERT_ENABLE_BIT = 10;
	localparam int PMCA_MSK_AFF_BIT = 4;
	localparam int PMCA_MSK_CONV_DONE_FLAG_BIT = 3;
	localparam int PMCA_MSK_ALERT_LEVEL_SELECT_BIT = 1;
	localparam int PMCA_MSK_LEN_BIT = 0;

	// arithmetic constants
	localparam int PMCA_CUR_DIV = 2048;
	localparam int PMCA_POW_DIV = 20000;
	localparam int PMCA_ACC_W = 24;                        // 16 bits plus up to 128 samples

	//////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [15:0] wdata;
	} pmca_req_t;

	typedef struct packed {
		logic [15:0] shunt;
		logic [15:0] bus;
	} pmca_pair_t;

	typedef enum logic [1:0] {S_OFF, S_WAKE, S_SHUNT, S_BUS} pmca_seq_t;

	typedef struct packed {
		logic [31:0] cnt;
		logic busy;
		logic done;
	} pmca_tmr_t;

endpackage : pmca_pkg

// ===== pmca_conv_timer.sv
// interval timer that paces recovery and every conversion
module pmca_conv_timer
	import pmca_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [31:0] load,
	output logic done
);

	pmca_tmr_t q, d;

	// load on start, count down, pulse done once the interval has run out
	always_comb
	begin
		d = q;
		d.done = 1'b0;
		if (start)
		begin
			d.cnt = load;
			d.busy = 1'b1;
		end
		else if (q.busy)
		begin
			d.cnt = q.cnt - 32'h1;
			if (q.cnt <= 32'h1)
			begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			q <= '0;
		else
			q <= d;
	end

	assign done = q.done;

endmodule : pmca_conv_timer

// ===== pmca_conv_alert.sv
// Summary of operation
// R1: wait 40 us recovery after power-down
// R2: registers stay accessible in power-down
// R3: no conversions until active mode written
// R4: ready flag set after conversions, averaging, math
// R5: configuration write clears ready flag unless power-down
// R6: mask/enable read clears ready flag
// R7: separate shunt and bus conversion times
// R8: current from calibration; zero if uncalibrated
// R9: power from previous current, new bus
// R10: accumulate samples, outputs untouched meanwhile
// R11: load averaged results together at completion
// R12: arithmetic overlaps next conversion, no added time
// R13: one threshold shared by five functions
// R14: alert asserts on threshold violation
// R15: highest enabled function wins
// R16: ready flag may also drive alert
// R17: without ready enable, only limit alerts
// R18: shunt functions compare after each shunt conversion
// R19: bus functions compare after each bus conversion
// R20: power over compares after each bus conversion
// R21: polarity bit sets alert active level
// R22: latched alert held until config write or mask read
// R23: unlatched alert follows latest comparison
// R24: each triggered write runs one sequence
// R25: mode 111 continuous, 001/010/011 single-shot
// R26: current = shunt * scale / 2048
// R27: power = current * bus / 20000
module pmca_conv_alert
	import pmca_pkg::*;
#(
	parameter int unsigned WAKE_CYC = PMCA_WAKE_CYC,       // recovery length in cycles
	parameter pmca_ct_arr_t CT_CYC = PMCA_CT_CYC           // conversion lengths in cycles
)
(
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire pmca_req_t REG_REQ,
	output logic [15:0] REG_RDATA,
	output logic REG_RVALID,
	input wire pmca_pair_t ADC_DATA,
	output logic ADC_POWER,
	output logic ADC_SHUNT_SEL,
	output logic ADC_BUS_SEL,
	output pmca_pair_t AVG_RESULT,
	output logic ALERT_O,
	output logic ALERT_OEN
);

	//////////////////////////////////////////////////////////////////////////////
	// elaboration checks: intervals of at least one cycle; the timer would run a zero interval as one cycle
	if (WAKE_CYC < 1)
	begin : g_wake_chk
		$error("recovery length must be at least one cycle");
	end
	for (genvar g = 0; g < 8; g++)
	begin : g_ct_chk
		if (CT_CYC[g] < 1)
		begin : g_bad
			$error("conversion length must be at least one cycle");
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// whole module state
	typedef struct packed {
		pmca_seq_t st;                    // sequencer state
		logic kick;                       // start the reset-time mode once
		logic powered;                    // front end out of power-down
		logic [15:0] cfg;                 // configuration
		logic [15:0] scale;               // current scale
		logic [4:0] fn_en;                // alert-function enables, bit 4 highest
		logic done_to_alert_enable;                       // ready flag drives alert
		logic alert_level_select;                       // alert level select
		logic len;                        // alert latch enable
		logic [15:0] limit;               // alert threshold
		logic conv_done_flag;                       // conversion done flag
		logic aff;                        // limit hit flag
		logic [15:0] shunt_res;           // averaged shunt
		logic [15:0] bus_res;             // averaged bus
		logic [15:0] cur_res;             // averaged current
		logic [15:0] pow_res;             // averaged power
		logic signed [PMCA_ACC_W-1:0] acc_sh;
		logic signed [PMCA_ACC_W-1:0] acc_bu;
		logic signed [PMCA_ACC_W-1:0] acc_cu;
		logic signed [PMCA_ACC_W-1:0] acc_pw;
		logic [7:0] cnv_n;                // sample sets converted
		logic [7:0] calc_n;               // sample sets calculated
		logic [15:0] last_cur;            // most recent current sample
		logic [15:0] samp_sh;             // shunt sample awaiting math
		logic [15:0] samp_bu;             // bus sample awaiting math
		logic p_sh;                       // shunt math pending
		logic p_bu;                       // bus math pending
		logic [15:0] rdata;
		logic rvalid;
		logic alert_oen;
	} pmca_st_t;

	pmca_st_t q, d;
	logic tmr_start;                      // start the interval timer
	logic [31:0] tmr_load;                // interval length
	logic tmr_done;                       // interval ended

	//////////////////////////////////////////////////////////////////////////////
	// helpers

	// divide an accumulated sum by the averaging count
	function automatic logic [15:0] pmca_avg(input logic signed [PMCA_ACC_W-1:0] a,
		input logic [2:0] code);
		logic signed [PMCA_ACC_W-1:0] s;
		s = a >>> code;
		return s[15:0];
	endfunction : pmca_avg

	// averaging count for a code, one to 128, a power of two so the divide is a shift
	function automatic logic [7:0] pmca_navg(input logic [2:0] code);
		return 8'h01 << code;
	endfunction : pmca_navg

	//////////////////////////////////////////////////////////////////////////////
	// interval timer shared by recovery and both conversions
	pmca_conv_timer u_timer (
		.clk(CORE_CLK),
		.rstn(RSTN),
		.start(tmr_start),
		.load(tmr_load),
		.done(tmr_done)
	);

	//////////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb
	begin
		logic [2:0] mode;
		logic [2:0] acode;
		logic [7:0] navg;
		logic wr_cfg;
		logic rd_mask;
		logic clr_conv_done_flag;
		logic set_conv_done_flag;
		logic hit_clr;
		logic restart;
		logic next_set;
		logic set_done;
		logic cmp_valid;
		logic cmp_hit;
		logic signed [15:0] sh;
		logic signed [15:0] lim;
		logic signed [32:0] cprod;
		logic signed [32:0] cquot;
		logic [15:0] cur;
		logic [15:0] cur_mag;
		logic [31:0] pprod;
		logic [31:0] pquot;
		logic [15:0] pw;
		logic asserted;

		d = q;
		mode = q.cfg[PMCA_CFG_MODE_LSB +: 3];
		acode = q.cfg[PMCA_CFG_AVG_LSB +: 3];
		navg = pmca_navg(acode);
		tmr_start = 1'b0;
		tmr_load = 32'h0;
		d.rvalid = 1'b0;
		d.kick = 1'b0;
		wr_cfg = REG_REQ.wr && (REG_REQ.addr == PMCA_OFS_CFG);
		rd_mask = REG_REQ.rd && (REG_REQ.addr == PMCA_OFS_MASK);
		set_conv_done_flag = 1'b0;
		next_set = 1'b0;
		cmp_valid = 1'b0;
		cmp_hit = 1'b0;
		lim = $signed(q.limit);
		sh = $signed(q.samp_sh);
		cur = 16'h0;
		pw = 16'h0;
		cprod = '0;
		cquot = '0;
		cur_mag = '0;
		pprod = '0;
		pquot = '0;

		// register reads work in every state, power-down included [R2]
		if (REG_REQ.rd)
		begin
			d.rvalid = 1'b1;
			case (REG_REQ.addr)
				PMCA_OFS_CFG: d.rdata = q.cfg;
				PMCA_OFS_SHUNT: d.rdata = q.shunt_res;
				PMCA_OFS_BUS: d.rdata = q.bus_res;
				PMCA_OFS_POWER: d.rdata = q.pow_res;
				PMCA_OFS_CURRENT: d.rdata = q.cur_res;
				PMCA_OFS_SCALE: d.rdata = q.scale;
				PMCA_OFS_MASK: d.rdata = {q.fn_en, q.done_to_alert_enable, 5'h00, q.aff, q.conv_done_flag, 1'b0, q.alert_level_select,
					q.len};
				PMCA_OFS_LIMIT: d.rdata = q.limit;
				default: d.rdata = 16'h0000;
			endcase
		end

		// register writes, also accepted while powered down [R2]
		if (REG_REQ.wr)
		begin
			case (REG_REQ.addr)
				PMCA_OFS_CFG: d.cfg = REG_REQ.wdata;
				PMCA_OFS_SCALE: d.scale = REG_REQ.wdata;
				PMCA_OFS_MASK:
				begin
					d.fn_en = REG_REQ.wdata[PMCA_MSK_EN_LSB +: 5];
					d.done_to_alert_enable = REG_REQ.wdata[PMCA_MSK_DONE_TO_ALERT_ENABLE_BIT];
					d.alert_level_select = REG_REQ.wdata[PMCA_MSK_ALERT_LEVEL_SELECT_BIT];
					d.len = REG_REQ.wdata[PMCA_MSK_LEN_BIT];
				end
				PMCA_OFS_LIMIT: d.limit = REG_REQ.wdata;  // one threshold for all functions [R13]
				default: ;                                 // read-only or unmapped: ignored
			endcase
		end

		// ready flag clears: config write except power-down [R5], mask read [R6]
		clr_conv_done_flag = rd_mask || (wr_cfg && (REG_REQ.wdata[PMCA_CFG_MODE_LSB +: 2] != 2'b00));
		// latched hit flag clears on config write or mask read [R22]
		hit_clr = rd_mask || wr_cfg;

		////////////////////////////////////////////////////////////////////////////
		// shunt math runs while the bus conversion already counts [R12]
		if (q.p_sh)
		begin
			d.p_sh = 1'b0;
			cprod = $signed({sh[15], sh}) * $signed({1'b0, q.scale});
			cquot = cprod / PMCA_CUR_DIV;                    // [R26]
			cur = (q.scale == 16'h0000) ? 16'h0000 : cquot[15:0];  // [R8]
			d.last_cur = cur;
			d.acc_sh = q.acc_sh + PMCA_ACC_W'(sh);           // [R10]
			d.acc_cu = q.acc_cu + PMCA_ACC_W'($signed(cur));
			// shunt functions watch every shunt sample [R18]
			if (q.fn_en[4])
			begin
				cmp_valid = 1'b1;
				cmp_hit = sh > lim;                          // shunt over [R14]
			end
			else if (q.fn_en[3])                             // lower priority [R15]
			begin
				cmp_valid = 1'b1;
				cmp_hit = sh < lim;                          // shunt under [R14]
			end
			if (!mode[1])
				next_set = 1'b1;
		end

		// bus and power math, power from the previous current [R9]
		if (q.p_bu)
		begin
			d.p_bu = 1'b0;
			cur_mag = q.last_cur[15] ? (16'h0000 - q.last_cur) : q.last_cur;
			pprod = cur_mag * q.samp_bu;
			pquot = pprod / PMCA_POW_DIV;                    // [R27]
			pw = (q.scale == 16'h0000) ? 16'h0000 : pquot[15:0];  // [R9]
			d.acc_bu = q.acc_bu + PMCA_ACC_W'({1'b0, q.samp_bu});  // [R10]
			d.acc_pw = q.acc_pw + PMCA_ACC_W'({1'b0, pw});
			// bus functions and power over watch every bus sample [R19] [R20]
			if (q.fn_en[4:3] == 2'b00)
			begin
				if (q.fn_en[2])
				begin
					cmp_valid = 1'b1;
					cmp_hit = q.samp_bu > q.limit;           // bus over [R19]
				end
				else if (q.fn_en[1])                         // [R15]
				begin
					cmp_valid = 1'b1;
					cmp_hit = q.samp_bu < q.limit;           // bus under [R19]
				end
				else if (q.fn_en[0])
				begin
					cmp_valid = 1'b1;
					cmp_hit = pw > q.limit;                  // power over [R20]
				end
			end
			next_set = 1'b1;
		end

		// each calculated sample set is counted; the last one of the average loads the results of the converted channels at once [R11]
		set_done = 1'b0;
		if (next_set)
		begin
			d.calc_n = q.calc_n + 8'h01;
			if (d.calc_n == navg)
			begin
				set_done = 1'b1;
				d.calc_n = 8'h00;
				if (mode[0])
				begin
					d.shunt_res = pmca_avg(d.acc_sh, acode);
					d.cur_res = pmca_avg(d.acc_cu, acode);
				end
				if (mode[1])
				begin
					d.bus_res = pmca_avg(d.acc_bu, acode);
					d.pow_res = pmca_avg(d.acc_pw, acode);
				end
				d.acc_sh = '0;
				d.acc_bu = '0;
				d.acc_cu = '0;
				d.acc_pw = '0;
				set_conv_done_flag = 1'b1;                             // math is done here [R4]
			end
		end

		////////////////////////////////////////////////////////////////////////////
		// conversion sequencer
		restart = wr_cfg || q.kick;
		if (restart)
		begin
			// any configuration write restarts, so each trigger runs once [R24]
			mode = d.cfg[PMCA_CFG_MODE_LSB +: 3];
			d.cnv_n = 8'h00;
			d.calc_n = 8'h00;
			d.p_sh = 1'b0;
			d.p_bu = 1'b0;
			d.acc_sh = '0;
			d.acc_bu = '0;
			d.acc_cu = '0;
			d.acc_pw = '0;
			if (mode[1:0] == 2'b00)
			begin
				// power-down: no conversions until an active mode [R3]
				d.st = S_OFF;
				d.powered = 1'b0;
			end
			else if (!q.powered)
			begin
				// leaving power-down, wait out the recovery [R1]
				d.st = S_WAKE;
				d.powered = 1'b1;
				tmr_start = 1'b1;
				tmr_load = WAKE_CYC;
			end
			else
			begin
				d.st = mode[0] ? S_SHUNT : S_BUS;            // single-shot or continuous [R25]
				tmr_start = 1'b1;
				tmr_load = mode[0] ? CT_CYC[d.cfg[PMCA_CFG_CTSH_LSB +: 3]]
					: CT_CYC[d.cfg[PMCA_CFG_CTBU_LSB +: 3]];
			end
		end
		else if (tmr_done)
		begin
			case (q.st)
				S_WAKE:
				begin
					d.st = mode[0] ? S_SHUNT : S_BUS;
					tmr_start = 1'b1;
					tmr_load = mode[0] ? CT_CYC[q.cfg[PMCA_CFG_CTSH_LSB +: 3]]
						: CT_CYC[q.cfg[PMCA_CFG_CTBU_LSB +: 3]];
				end
				S_SHUNT, S_BUS:
				begin
					if (q.st == S_SHUNT)
					begin
						d.samp_sh = ADC_DATA.shunt;
						d.p_sh = 1'b1;
					end
					else
					begin
						d.samp_bu = ADC_DATA.bus;
						d.p_bu = 1'b1;
					end
					if ((q.st == S_SHUNT) && mode[1])
					begin
						// shunt then bus, each with its own time [R7]
						d.st = S_BUS;
						tmr_start = 1'b1;
						tmr_load = CT_CYC[q.cfg[PMCA_CFG_CTBU_LSB +: 3]];
					end
					else if ((q.cnv_n + 8'h01 == navg) && !mode[2])
					begin
						// single-shot finished, front end stays powered [R25]
						d.cnv_n = 8'h00;
						d.st = S_OFF;
					end
					else
					begin
						d.cnv_n = (q.cnv_n + 8'h01 == navg) ? 8'h00 : q.cnv_n + 8'h01;
						d.st = mode[0] ? S_SHUNT : S_BUS;
						tmr_start = 1'b1;
						tmr_load = mode[0] ? CT_CYC[q.cfg[PMCA_CFG_CTSH_LSB +: 3]]
							: CT_CYC[q.cfg[PMCA_CFG_CTBU_LSB +: 3]];
					end
				end
				default: ;                                   // idle: stray done ignored
			endcase
		end

		////////////////////////////////////////////////////////////////////////////
		// flags: a set in the same cycle as a clear wins
		d.conv_done_flag = (q.conv_done_flag && !clr_conv_done_flag) || set_conv_done_flag;      // [R4] [R5] [R6]
		if (q.len)
		begin
			d.aff = (q.aff && !hit_clr) || (cmp_valid && cmp_hit);  // [R22]
		end
		else if (cmp_valid)
		begin
			d.aff = cmp_hit;                                 // follow latest result [R23]
		end

		// alert pin: limit hit, plus ready flag when enabled [R16] [R17]
		asserted = d.aff || (d.done_to_alert_enable && d.conv_done_flag);
		// level select: clear means active low, set means active high [R21]
		d.alert_oen = d.alert_level_select ? asserted : !asserted;
	end

	//////////////////////////////////////////////////////////////////////////////
	// state register, reset into the default continuous configuration
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			q <= '0;
			q.st <= S_OFF;
			q.kick <= 1'b1;
			q.cfg <= PMCA_CFG_RST;
			q.alert_oen <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// outputs
	assign REG_RDATA = q.rdata;
	assign REG_RVALID = q.rvalid;
	assign ADC_POWER = q.powered;
	assign ADC_SHUNT_SEL = (q.st == S_SHUNT);
	assign ADC_BUS_SEL = (q.st == S_BUS);
	assign AVG_RESULT.shunt = q.shunt_res;
	assign AVG_RESULT.bus = q.bus_res;
	// open drain: only ever pulls low, the enable decides
	assign ALERT_O = 1'b0;
	assign ALERT_OEN = q.alert_oen;

endmodule : pmca_conv_alert

// ===== pmca_fe_model.sv
// front-end model: hands the converter a sample only inside its own conversion window
module pmca_fe_model
	import pmca_pkg::*;
(
	input wire logic power,
	input wire logic shunt_sel,
	input wire logic bus_sel,
	input wire logic [15:0] shunt_v,
	input wire logic [15:0] bus_v,
	output pmca_pair_t data
);
	timeunit 1ns;
	timeprecision 1ps;

	//////////////////////////////////////////////////////////////////////////////
	// outside a window the inverse shows, so a sample taken at the wrong time is caught
	always_comb
	begin
		data.shunt = (power && shunt_sel) ? shunt_v : ~shunt_v;
		data.bus = (power && bus_sel) ? bus_v : ~bus_v;
	end
endmodule : pmca_fe_model

// ===== pmca_conv_alert_props.sv
// port-level checker for the sequencer and alert logic
module pmca_conv_alert_chk
	import pmca_pkg::*;
#(
	parameter int unsigned WAKE_CYC = PMCA_WAKE_CYC, // recovery length in cycles
	parameter pmca_ct_arr_t CT_CYC = PMCA_CT_CYC // conversion lengths in cycles
)
(
	input wire logic CORE_CLK,
	input wire logic RSTN,
	input wire pmca_req_t REG_REQ,
	input wire logic [15:0] REG_RDATA,
	input wire logic REG_RVALID,
	input wire logic ADC_POWER,
	input wire logic ADC_SHUNT_SEL,
	input wire logic ADC_BUS_SEL,
	input wire logic ALERT_O,
	input wire logic ALERT_OEN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);

	//////////////////////////////////////////////////////////////////////////////
	logic wcfg; // configuration write taken
	logic wmsk; // mask write taken
	logic rmsk; // mask read taken
	logic [15:0] cfg_q; // shadow of the configuration
	logic [1:0] msk_q; // shadow of polarity and latch bits
	logic [1:0] ev_q; // recent events that may move the alert pin
	logic [31:0] pw_n; // cycles with the front end powered
	logic [31:0] sh_n; // cycles of the running shunt window
	logic [31:0] bu_n; // cycles of the running bus window
	assign wcfg = REG_REQ.wr && REG_REQ.addr == PMCA_OFS_CFG;
	assign wmsk = REG_REQ.wr && REG_REQ.addr == PMCA_OFS_MASK;
	assign rmsk = REG_REQ.rd && REG_REQ.addr == PMCA_OFS_MASK;

	// shadows and counters; the event history covers the two-cycle pin lag
	always_ff @(posedge CORE_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			cfg_q <= PMCA_CFG_RST;
			msk_q <= 2'h0;
			ev_q <= 2'h0;
			pw_n <= 32'h0;
			sh_n <= 32'h0;
			bu_n <= 32'h0;
		end
		else
		begin
			if (wcfg)
				cfg_q <= REG_REQ.wdata;
			if (wmsk)
				msk_q <= REG_REQ.wdata[1:0];
			ev_q <= {ev_q[0], wcfg | wmsk | rmsk};
			pw_n <= ADC_POWER ? pw_n + 32'h1 : 32'h0;
			sh_n <= ADC_SHUNT_SEL ? sh_n + 32'h1 : 32'h0;
			bu_n <= ADC_BUS_SEL ? bu_n + 32'h1 : 32'h0;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	AST_RVALID: assert property (REG_RVALID == $past(REG_REQ.rd))
		else $error("read answer not one cycle after the request");
	AST_UNMAPPED: assert property (REG_REQ.rd && REG_REQ.addr > 8'h07 |=> REG_RDATA == 16'h0000)
		else $error("unmapped read returned data");
	AST_ALERT_OD: assert property (ALERT_O == 1'b0)
		else $error("alert pin drives high");
	AST_PD_NOSEL: assert property (!ADC_POWER |-> !ADC_SHUNT_SEL && !ADC_BUS_SEL)
		else $error("conversion while powered down");
	AST_WAKE: assert property ($rose(ADC_SHUNT_SEL) |-> pw_n > WAKE_CYC)
		else $error("conversion started inside recovery");
	AST_SH_LEN: assert property ($fell(ADC_SHUNT_SEL) && !$past(wcfg)
		|-> sh_n == CT_CYC[cfg_q[5:3]] + 1)
		else $error("shunt window length wrong");
	AST_BU_LEN: assert property ($fell(ADC_BUS_SEL) && !$past(wcfg)
		|-> bu_n == CT_CYC[cfg_q[8:6]] + 1)
		else $error("bus window length wrong");
	AST_SH_TO_BUS: assert property ($fell(ADC_SHUNT_SEL) && !$past(wcfg) && cfg_q[1]
		|-> ADC_BUS_SEL)
		else $error("gap between shunt and bus windows");
	AST_LATCH_HOLD: assert property (msk_q[0] && ALERT_OEN == msk_q[1] && !wcfg && !wmsk
		&& !rmsk && ev_q == 2'h0 |=> $stable(ALERT_OEN))
		else $error("latched alert released on its own");

	C_BUS_DONE: cover property ($fell(ADC_BUS_SEL));
	C_READY_READ: cover property (rmsk ##1 REG_RDATA[PMCA_MSK_CONV_DONE_FLAG_BIT]);
	C_LATCHED: cover property (msk_q[0] && ALERT_OEN == msk_q[1]);
endmodule : pmca_conv_alert_chk

bind pmca_conv_alert pmca_conv_alert_chk #(.WAKE_CYC(WAKE_CYC), .CT_CYC(CT_CYC)) u_chk (
	.CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
	.REG_RVALID(REG_RVALID), .ADC_POWER(ADC_POWER), .ADC_SHUNT_SEL(ADC_SHUNT_SEL),
	.ADC_BUS_SEL(ADC_BUS_SEL), .ALERT_O(ALERT_O), .ALERT_OEN(ALERT_OEN));

// ===== tb.sv
// self-checking bench: host register tasks plus the front-end model
module tb
	import pmca_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// short distinct windows keep the run brief while codes stay distinguishable
	localparam pmca_ct_arr_t CT = '{10, 12, 14, 16, 18, 20, 22, 24};
	localparam logic [15:0] TRIG = 16'h4123; // single shot, shunt and bus, ct code 4
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	pmca_req_t req = '0;
	logic [15:0] rdata, shunt_v = 16'h1F40, bus_v = 16'h2570;
	logic rvalid, pwr, shsel, busel, al_o, al_oen;
	pmca_pair_t adc, avg;
	int err_total = 0;
	int n_compared = 0;

	always #2.5 core_clk = ~core_clk;

	pmca_conv_alert #(.WAKE_CYC(4), .CT_CYC(CT)) uut (.CORE_CLK(core_clk), .RSTN(rstn),
		.REG_REQ(req), .REG_RDATA(rdata), .REG_RVALID(rvalid), .ADC_DATA(adc),
		.ADC_POWER(pwr), .ADC_SHUNT_SEL(shsel), .ADC_BUS_SEL(busel), .AVG_RESULT(avg),
		.ALERT_O(al_o), .ALERT_OEN(al_oen));
	pmca_fe_model fe (.power(pwr), .shunt_sel(shsel), .bus_sel(busel), .shunt_v(shunt_v),
		.bus_v(bus_v), .data(adc));

	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// request held over one rising edge, dropped at the next falling edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge core_clk);
		req.wr = 1'b0;
	endtask : wr

	// a missing answer turns into unknown data and fails the compare
	task automatic rchk(input logic [7:0] a, input logic [15:0] e);
		int n;
		@(negedge core_clk);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge core_clk);
		req.rd = 1'b0;
		n = 0;
		while (rvalid !== 1'b1 && n < 4)
		begin
			@(negedge core_clk);
			n++;
		end
		chk(rvalid === 1'b1 ? rdata : 16'hXXXX, e);
	endtask : rchk

	task automatic wait_sel(input bit bus, input logic lvl);
		int n;
		n = 0;
		while ((bus ? busel : shsel) !== lvl && n < 400)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n == 400)
		begin
			err_total++;
			$display("Error at %0t: conversion stalled", $time);
		end
	endtask : wait_sel

	task automatic wait_done;
		wait_sel(1'b1, 1'b1);
		wait_sel(1'b1, 1'b0);
		repeat (4) @(negedge core_clk);
	endtask : wait_done

	// counts window starts over a fixed span
	task automatic cnt(input int cyc, output logic [15:0] s, output logic [15:0] b);
		logic ps, pb;
		s = 16'h0000;
		b = 16'h0000;
		ps = 1'b0;
		pb = 1'b0;
		repeat (cyc)
		begin
			@(negedge core_clk);
			if (shsel && !ps)
				s++;
			if (busel && !pb)
				b++;
			ps = shsel;
			pb = busel;
		end
	endtask : cnt

	//////////////////////////////////////////////////////////////////////////////
	task automatic s_reset;
		chk({15'h0, al_oen}, 16'h0001);
		rchk(PMCA_OFS_CFG, PMCA_CFG_RST);
		rchk(PMCA_OFS_LIMIT, 16'h0000);
		rchk(8'h08, 16'h0000);
		wr(PMCA_OFS_CURRENT, 16'hFFFF);
		wait_done;
		rchk(PMCA_OFS_CURRENT, 16'h0000);
		rchk(PMCA_OFS_POWER, 16'h0000);
	endtask : s_reset

	// power-down write keeps the ready flag; the mask read then clears it
	task automatic s_pdown;
		logic [15:0] s, b;
		wr(PMCA_OFS_CFG, 16'h4120);
		rchk(PMCA_OFS_MASK, 16'h0008);
		rchk(PMCA_OFS_MASK, 16'h0000);
		wr(PMCA_OFS_LIMIT, 16'h1234);
		rchk(PMCA_OFS_LIMIT, 16'h1234);
		cnt(100, s, b);
		chk(s | b, 16'h0000);
		chk({15'h0, pwr}, 16'h0000);
	endtask : s_pdown

	task automatic s_trig;
		logic [15:0] s, b;
		int n;
		wr(PMCA_OFS_SCALE, 16'h0A00);
		wr(PMCA_OFS_CFG, TRIG);
		n = 0;
		while (!shsel && n < 100)
		begin
			@(negedge core_clk);
			n++;
		end
		chk(16'(n >= 4), 16'h0001);
		wait_done;
		rchk(PMCA_OFS_CURRENT, 16'h2710);
		rchk(PMCA_OFS_POWER, 16'h12B8);
		rchk(PMCA_OFS_SHUNT, 16'h1F40);
		rchk(PMCA_OFS_BUS, 16'h2570);
		rchk(PMCA_OFS_MASK, 16'h0008);
		for (int m = 1; m < 4; m++)
		begin
			wr(PMCA_OFS_CFG, {TRIG[15:3], 3'(m)});
			cnt(80, s, b);
			chk(s, 16'(m & 1));
			chk(b, 16'(m >> 1));
		end
	endtask : s_trig

	// shortest shunt code with longest bus code
	task automatic s_ctime;
		int n;
		wr(PMCA_OFS_CFG, 16'h41C3);
		rchk(PMCA_OFS_MASK, 16'h0000);
		wait_sel(1'b0, 1'b0);
		n = 0;
		while (busel && n < 100)
		begin
			n++;
			@(negedge core_clk);
		end
		chk(16'(n), 16'(CT[7] + 1));
		repeat (4) @(negedge core_clk);
	endtask : s_ctime

	// two samples with different values; outputs move only at the end
	task automatic s_avg;
		shunt_v = 16'h0064;
		bus_v = 16'h03E8;
		wr(PMCA_OFS_CFG, 16'h4323);
		wait_sel(1'b0, 1'b1);
		wait_sel(1'b0, 1'b0);
		shunt_v = 16'h012C;
		wait_sel(1'b1, 1'b0);
		bus_v = 16'h0BB8;
		rchk(PMCA_OFS_SHUNT, 16'h1F40);
		rchk(PMCA_OFS_CURRENT, 16'h2710);
		wait_done;
		rchk(PMCA_OFS_SHUNT, 16'h00C8);
		rchk(PMCA_OFS_CURRENT, 16'h00FA);
		rchk(PMCA_OFS_POWER, 16'h001F);
		chk(avg.bus, 16'h07D0);
	endtask : s_avg

	// limit, mask, expected pin release for shunt 300, bus 3000, power 56
	task automatic s_alert;
		logic [15:0] t [8][3] = '{'{16'h0100, 16'h8000, 16'h0000},
			'{16'h0100, 16'h4000, 16'h0001}, '{16'h0100, 16'h2000, 16'h0000},
			'{16'h0100, 16'h1000, 16'h0001}, '{16'h0010, 16'h0800, 16'h0000},
			'{16'h0200, 16'hA000, 16'h0001}, '{16'h0100, 16'h8002, 16'h0001},
			'{16'h0100, 16'h4002, 16'h0000}};
		for (int i = 0; i < 8; i++)
		begin
			wr(PMCA_OFS_LIMIT, t[i][0]);
			wr(PMCA_OFS_MASK, t[i][1]);
			wr(PMCA_OFS_CFG, TRIG);
			wait_done;
			chk({15'h0, al_oen}, t[i][2]);
		end
		wr(PMCA_OFS_MASK, 16'h0400);
		wr(PMCA_OFS_CFG, TRIG);
		wait_done;
		chk({15'h0, al_oen}, 16'h0000);
		rchk(PMCA_OFS_MASK, 16'h0408);
		repeat (3) @(negedge core_clk);
		chk({15'h0, al_oen}, 16'h0001);
		wr(PMCA_OFS_MASK, 16'h8001);
		wr(PMCA_OFS_CFG, TRIG);
		wait_done;
		repeat (30) @(negedge core_clk);
		chk({15'h0, al_oen}, 16'h0000);
		rchk(PMCA_OFS_MASK, 16'h8019);
		repeat (3) @(negedge core_clk);
		chk({15'h0, al_oen}, 16'h0001);
		rchk(PMCA_OFS_LIMIT, 16'h0100);
	endtask : s_alert

	//////////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("compared %0d, errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	// main sequence after four reset cycles
	initial
	begin
		repeat (4) @(negedge core_clk);
		rstn = 1'b1;
		s_reset;
		s_pdown;
		s_trig;
		s_ctime;
		s_avg;
		s_alert;
		complete_run;
	end

	// the whole run needs a little over a thousand cycles; a hang is cut well beyond that
	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		$display("Error at %0t: watchdog expired", $time);
		complete_run;
	end
endmodule : tb
